/* File: rtl/zpg_pkg.sv */
package zpg_pkg;
    localparam int PH_W = 24;
    localparam int AMP_W = 11;
    localparam int OUT_W = 16;
    localparam int SIN_AW = 8;
    localparam int SIN_DW = 12;
    localparam int N_COEF = 10;
    localparam int CNT_W = 16;
    localparam logic [7:0] A_COEF0 = 8'h00;
    localparam logic [7:0] A_AMP = 8'h28;
    localparam logic [7:0] A_CTRL = 8'h2c;
    localparam logic [7:0] A_STAT = 8'h30;
    localparam int C_PHI = 0;
    localparam int C_X = 1;
    localparam int C_X2 = 2;
    localparam int C_XY = 3;
    localparam int C_Y = 4;
    localparam int C_Y2 = 5;
    localparam int C_XT = 6;
    localparam int C_YT = 7;
    localparam int C_T = 8;
    localparam int C_T2 = 9;
    localparam int CTRL_ENA_LSB = 0;
    localparam int CTRL_RGB = 3;
    localparam int CTRL_RESTORE = 4;
    localparam logic [AMP_W-1:0] AMP_DEFAULT = 11'h578;
    localparam logic [AMP_W-1:0] AMP_MAX = 11'h63c;
    localparam logic [2:0] ENA_YCC = 3'h1;
    localparam logic [2:0] ENA_RGB = 3'h7;
    localparam logic [PH_W-1:0] COEF_RESET = 24'h000000;
    localparam int PIPE_LAT = 4;
endpackage

/* File: rtl/zpg_sine_rom.sv */
`timescale 1ns/10ps
module zpg_sine_rom #(
    parameter int AW = 8,
    parameter int DW = 12
) (
    input wire logic clock,
    input wire logic clk_en,
    input wire logic [AW-1:0] addr,
    output logic [DW-1:0] rdata
);
    localparam real PI = 3.14159265358979;
    logic [DW-1:0] table_q [2**AW];

    if (AW < 4 || DW < 4 || DW > 16) begin : g_bad
        $error("zpg_sine_rom: unsupported table size");
    end

    // Quarter wave sampled at bin centres so mirrored addresses never repeat zero.
    for (genvar i = 0; i < 2**AW; i++) begin : g_tab
        localparam int V = $rtoi($sin((real'(i) + 0.5) * PI / (2.0 * real'(2**AW)))
                                 * real'(2**(DW-1) - 1) + 0.5);
        assign table_q[i] = V[DW-1:0];
    end

    always_ff @(posedge clock) begin
        if (clk_en) begin
            rdata <= table_q[addr];
        end
    end
endmodule

/* File: rtl/zpg_generator.sv */
`timescale 1ns/10ps
// Overview of operation
// - Phase sums constant, linear, cross terms and half of each square term.
// - Output level of each point follows the sine of its phase.
// - Amplitude settable zero to upper limit in 0.5 mV steps; scales sine.
// - Reset or restore of defaults loads the default 700 mV amplitude.
// - Horizontal coefficient gives a constant phase advance along each line.
// - Horizontal frequency is limited to plus or minus half the sample rate.
// - Horizontal square coefficient sweeps frequency with position along the line.
// - Cross coefficient changes horizontal frequency line by line.
// - Vertical coefficient gives a constant vertical frequency down the frame.
// - Vertical square coefficient sweeps vertical frequency down the frame.
// - Constant phase coefficient is added to every sample.
// - Horizontal frequency rises with time, flips phase at maximum, repeats.
// - Vertical frequency rises with time, flips phase at maximum, repeats.
// - Temporal coefficient alone swings the whole picture sinusoidally over time.
// - Signed temporal coefficient; negative sign reverses apparent motion.
// - Temporal frequency rises by its square coefficient, flips phase at maximum, repeats.
// - Three independent component enables; pattern only on enabled components.
// - Default enables: luma only for colour difference, all three for RGB.
module zpg_generator
    import zpg_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    input wire logic clk_en,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic frame_start,
    input wire logic line_start,
    input wire logic active_in,
    output logic video_valid,
    output logic [zpg_pkg::OUT_W-1:0] comp0,
    output logic [zpg_pkg::OUT_W-1:0] comp1,
    output logic [zpg_pkg::OUT_W-1:0] comp2
);
    import zpg_pkg::*;

    function automatic logic is_coef(input logic [7:0] a);
        return (a[1:0] == 2'h0) && (a[7:2] < 6'(N_COEF));
    endfunction

    function automatic logic [PH_W-1:0] half(input logic [PH_W-1:0] v);
        return $signed(v) >>> 1;
    endfunction

    // Software-visible shadow set and the set the pattern actually uses.
    logic [PH_W-1:0] coef_sh [N_COEF];
    logic [PH_W-1:0] coef [N_COEF];
    logic [AMP_W-1:0] pattern_amplitude_sh;
    logic [AMP_W-1:0] pattern_amplitude;
    logic [2:0] comp_enable_sh;
    logic [2:0] comp_enable;
    logic rgb_space;
    logic [CNT_W-1:0] line_count;
    logic [CNT_W-1:0] frame_count;

    // Time accumulators, updated once per frame.
    logic [PH_W-1:0] time_h;
    logic [PH_W-1:0] time_v;
    logic [PH_W-1:0] time_sweep;
    logic [PH_W-1:0] time_phase;
    // Line and sample accumulators.
    logic [PH_W-1:0] line_phase;
    logic [PH_W-1:0] line_step;
    logic [PH_W-1:0] horiz_base;
    logic [PH_W-1:0] sample_phase;
    logic [PH_W-1:0] sample_step;

    // Sine pipeline.
    logic [PH_W-1:0] phase_p1;
    logic valid_p1;
    logic valid_p2;
    logic neg_p2;
    logic valid_p3;
    logic [SIN_DW-1:0] rom_data;
    logic signed [SIN_DW+AMP_W:0] prod_p3;

    wire logic [5:0] widx = reg_addr[7:2];
    wire logic wr_coef = reg_wr && is_coef(reg_addr);
    wire logic wr_amp = reg_wr && (reg_addr == A_AMP);
    wire logic wr_ctrl = reg_wr && (reg_addr == A_CTRL);
    wire logic restore = wr_ctrl && reg_wdata[CTRL_RESTORE];
    wire logic next_rgb = wr_ctrl ? reg_wdata[CTRL_RGB] : rgb_space;
    wire logic [AMP_W-1:0] amp_req = (reg_wdata[31:AMP_W] != '0) ? AMP_MAX
                                   : reg_wdata[AMP_W-1:0];
    wire logic [AMP_W-1:0] amp_clamped = (amp_req > AMP_MAX) ? AMP_MAX : amp_req;

    // Time terms as they stand for the frame that is starting.
    wire logic [PH_W-1:0] next_time_h = time_h + coef_sh[C_XT];
    wire logic [PH_W-1:0] next_time_v = time_v + coef_sh[C_YT];
    wire logic [PH_W-1:0] next_time_phase = time_phase + coef_sh[C_T] + time_sweep
                                          + half(coef_sh[C_T2]);

    wire logic [SIN_AW-1:0] rom_addr = phase_p1[PH_W-2] ? ~phase_p1[PH_W-3 -: SIN_AW]
                                                       : phase_p1[PH_W-3 -: SIN_AW];
    wire logic signed [SIN_DW-1:0] sine_p2 = neg_p2 ? -$signed(rom_data)
                                                    : $signed(rom_data);
    wire logic signed [OUT_W-1:0] level = OUT_W'(prod_p3 >>> AMP_W);

    if (PH_W < SIN_AW + 2 || AMP_W + SIN_DW > OUT_W + AMP_W + 1) begin : g_bad
        $error("zpg_generator: package widths cannot be served");
    end

    // Register writes.
    for (genvar i = 0; i < N_COEF; i++) begin : g_coef
        always_ff @(posedge clock) begin
            if (srst) begin
                coef_sh[i] <= COEF_RESET;
            end else if (clk_en) begin
                if (restore) begin
                    coef_sh[i] <= COEF_RESET;
                end else if (wr_coef && widx == 6'(i)) begin
                    coef_sh[i] <= reg_wdata[PH_W-1:0];
                end
            end
        end

        // No frame mixes two coefficient sets: the copy happens only here.
        always_ff @(posedge clock) begin
            if (srst) begin
                coef[i] <= COEF_RESET;
            end else if (clk_en && frame_start) begin
                coef[i] <= coef_sh[i];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            pattern_amplitude_sh <= AMP_DEFAULT;
            comp_enable_sh <= ENA_YCC;
            rgb_space <= 1'b0;
        end else if (clk_en) begin
            rgb_space <= next_rgb;
            if (restore) begin
                pattern_amplitude_sh <= AMP_DEFAULT;
                comp_enable_sh <= next_rgb ? ENA_RGB : ENA_YCC;
            end else begin
                if (wr_amp) begin
                    pattern_amplitude_sh <= amp_clamped;
                end
                if (wr_ctrl) begin
                    comp_enable_sh <= reg_wdata[CTRL_ENA_LSB +: 3];
                end
            end
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            pattern_amplitude <= AMP_DEFAULT;
            comp_enable <= ENA_YCC;
        end else if (clk_en && frame_start) begin
            pattern_amplitude <= pattern_amplitude_sh;
            comp_enable <= comp_enable_sh;
        end
    end

    // Register reads: data stand after the strobe until the next enabled clock edge.
    always_ff @(posedge clock) begin
        if (srst) begin
            reg_rdata <= 32'h0;
        end else if (clk_en) begin
            reg_rdata <= 32'h0;
            if (reg_rd) begin
                if (is_coef(reg_addr)) begin
                    reg_rdata <= 32'($signed(coef_sh[widx[3:0]]));
                end else if (reg_addr == A_AMP) begin
                    reg_rdata <= 32'(pattern_amplitude_sh);
                end else if (reg_addr == A_CTRL) begin
                    reg_rdata <= {28'h0, rgb_space, comp_enable_sh};
                end else if (reg_addr == A_STAT) begin
                    reg_rdata <= {frame_count, line_count};
                end
            end
        end
    end

    // Frame-rate time terms. Modular phase arithmetic makes the swept
    // frequencies alias past half the sample rate, which is the phase flip.
    always_ff @(posedge clock) begin
        if (srst) begin
            time_h <= '0;
            time_v <= '0;
            time_sweep <= '0;
            time_phase <= '0;
            frame_count <= '0;
        end else if (clk_en && frame_start) begin
            time_h <= next_time_h;
            time_v <= next_time_v;
            time_sweep <= time_sweep + coef_sh[C_T2];
            time_phase <= next_time_phase;
            frame_count <= frame_count + 1'b1;
        end
    end

    // Line-rate terms: phase at x = 0 and per-sample step for each line.
    always_ff @(posedge clock) begin
        if (srst) begin
            line_phase <= '0;
            line_step <= '0;
            horiz_base <= '0;
            line_count <= '0;
        end else if (clk_en) begin
            if (frame_start) begin
                line_phase <= coef_sh[C_PHI] + next_time_phase;
                line_step <= coef_sh[C_Y] + next_time_v + half(coef_sh[C_Y2]);
                horiz_base <= coef_sh[C_X] + next_time_h;
                line_count <= '0;
            end else if (line_start) begin
                line_phase <= line_phase + line_step;
                line_step <= line_step + coef[C_Y2];
                horiz_base <= horiz_base + coef[C_XY];
                line_count <= line_count + 1'b1;
            end
        end
    end

    // Sample-rate terms along the active line.
    always_ff @(posedge clock) begin
        if (srst) begin
            sample_phase <= '0;
            sample_step <= '0;
        end else if (clk_en) begin
            if (line_start) begin
                sample_phase <= line_phase;
                sample_step <= horiz_base + half(coef[C_X2]);
            end else if (active_in) begin
                // Step is a cycle fraction per sample, so it cannot pass half
                // the sample rate; larger values alias in sign.
                sample_phase <= sample_phase + sample_step;
                sample_step <= sample_step + coef[C_X2];
            end
        end
    end

    // Stage 1: capture phase of the current sample.
    always_ff @(posedge clock) begin
        if (srst) begin
            phase_p1 <= '0;
            valid_p1 <= 1'b0;
        end else if (clk_en) begin
            phase_p1 <= sample_phase;
            valid_p1 <= active_in && !line_start;
        end
    end

    zpg_sine_rom #(
        .AW(SIN_AW),
        .DW(SIN_DW)
    ) u_rom (
        .clock(clock),
        .clk_en(clk_en),
        .addr(rom_addr),
        .rdata(rom_data)
    );

    // Stage 2 and 3: sign restore and amplitude scaling.
    always_ff @(posedge clock) begin
        if (srst) begin
            valid_p2 <= 1'b0;
            neg_p2 <= 1'b0;
            valid_p3 <= 1'b0;
            prod_p3 <= '0;
        end else if (clk_en) begin
            valid_p2 <= valid_p1;
            neg_p2 <= phase_p1[PH_W-1];
            valid_p3 <= valid_p2;
            prod_p3 <= sine_p2 * $signed({1'b0, pattern_amplitude});
        end
    end

    // Stage 4: disabled components sit at zero level.
    always_ff @(posedge clock) begin
        if (srst) begin
            video_valid <= 1'b0;
            comp0 <= '0;
            comp1 <= '0;
            comp2 <= '0;
        end else if (clk_en) begin
            video_valid <= valid_p3;
            comp0 <= (valid_p3 && comp_enable[0]) ? level : '0;
            comp1 <= (valid_p3 && comp_enable[1]) ? level : '0;
            comp2 <= (valid_p3 && comp_enable[2]) ? level : '0;
        end
    end
endmodule

/* File: tb/zpg_generator_props.sv */
`timescale 1ns/10ps
module zpg_generator_props
    import zpg_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    input wire logic clk_en,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic frame_start,
    input wire logic line_start,
    input wire logic active_in,
    input wire logic video_valid,
    input wire logic [zpg_pkg::OUT_W-1:0] comp0,
    input wire logic [zpg_pkg::OUT_W-1:0] comp1,
    input wire logic [zpg_pkg::OUT_W-1:0] comp2
);
    import zpg_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    sample_latency_a: assert property (
        active_in && !line_start && clk_en ##1 clk_en[*3] |=> video_valid)
        else $error("accepted sample did not appear after four enabled cycles");
    no_stray_sample_a: assert property (
        (!active_in || line_start) && clk_en ##1 clk_en[*3] |=> !video_valid)
        else $error("sample appeared without an accepted active input");
    idle_level_zero_a: assert property (
        !video_valid |-> comp0 == '0 && comp1 == '0 && comp2 == '0)
        else $error("component level not zero outside valid samples");
    reset_clear_a: assert property (
        $past(srst) && !srst |-> !video_valid && reg_rdata == '0 && comp0 == '0)
        else $error("outputs not cleared by reset");
    rdata_idle_a: assert property (clk_en && !reg_rd |=> reg_rdata == '0)
        else $error("read data not zero without a read");
    level_bound_a: assert property (
        video_valid |-> $signed(comp0) <= 1596 && $signed(comp0) >= -1596
            && $signed(comp1) <= 1596 && $signed(comp1) >= -1596
            && $signed(comp2) <= 1596 && $signed(comp2) >= -1596)
        else $error("level beyond the amplitude limit");
    freeze_hold_a: assert property (
        !clk_en |=> $stable(comp0) && $stable(video_valid) && $stable(reg_rdata))
        else $error("state moved while clock enable was low");
    amp_limit_a: assert property (
        clk_en && reg_rd && reg_addr == A_AMP |=> reg_rdata <= 32'(AMP_MAX))
        else $error("amplitude reads above its limit");
    ctrl_upper_a: assert property (
        clk_en && reg_rd && reg_addr == A_CTRL |=> reg_rdata[31:4] == '0)
        else $error("control upper bits not zero");
endmodule
bind zpg_generator zpg_generator_props chk (.clock, .srst, .clk_en, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .frame_start, .line_start, .active_in, .video_valid, .comp0, .comp1, .comp2);

/* File: tb/zpg_monitor.sv */
`timescale 1ns/10ps
module zpg_monitor
    import zpg_pkg::*;
(
    input wire logic clock,
    input wire logic video_valid,
    input wire logic [zpg_pkg::OUT_W-1:0] comp0,
    input wire logic [zpg_pkg::OUT_W-1:0] comp1,
    input wire logic [zpg_pkg::OUT_W-1:0] comp2
);
    import zpg_pkg::*;
    // The sink has no back-pressure, so it simply records every valid sample.
    logic [OUT_W-1:0] q0[$];
    logic [OUT_W-1:0] q1[$];
    logic [OUT_W-1:0] q2[$];
    always @(posedge clock) begin
        if (video_valid === 1'b1) begin
            q0.push_back(comp0);
            q1.push_back(comp1);
            q2.push_back(comp2);
        end
    end
endmodule

/* File: tb/zone_plate_pattern_generator_test.sv */
`timescale 1ns/10ps
module zone_plate_pattern_generator_test;
    import zpg_pkg::*;
    logic clock = 0, srst = 1, clk_en = 1, reg_wr = 0, reg_rd = 0;
    logic frame_start = 0, line_start = 0, active_in = 0, video_valid;
    logic [7:0] reg_addr = 0;
    logic [31:0] reg_wdata = 0, reg_rdata, seed = 32'he1e3, v;
    logic [OUT_W-1:0] comp0, comp1, comp2;
    logic [2:0] e;
    int errors = 0, cmp_count = 0, a;
    // Sine codes per sample for each test pattern.
    // The quarter table holds bin centres, so a zero phase gives six and a half-cycle phase minus six, not zero.
    int pat[6][4] = '{'{2047, -6, -2047, 6}, '{4{2047}}, '{4{6}}, '{4{-2047}},
        '{6, -2047, 6, -2047}, '{6, 2047, -6, -2047}};
    always #5 clock = ~clock;
    zpg_generator uut (.clock(clock), .srst(srst), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .frame_start(frame_start), .line_start(line_start), .active_in(active_in),
        .video_valid(video_valid), .comp0(comp0), .comp1(comp1), .comp2(comp2));
    zpg_monitor mon (.clock(clock), .video_valid(video_valid), .comp0(comp0), .comp1(comp1),
        .comp2(comp2));
    function logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task results();
        $display("comparisons %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] ad, input logic [31:0] d);
        reg_wr <= 1;
        reg_addr <= ad;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 0;
        @(posedge clock);
    endtask
    task rd(input logic [7:0] ad, input logic [31:0] exp);
        reg_rd <= 1;
        reg_addr <= ad;
        @(posedge clock);
        reg_rd <= 0;
        @(posedge clock);
        chk(reg_rdata, exp);
    endtask
    task run_line(input bit fs);
        if (fs) begin
            frame_start <= 1;
            @(posedge clock);
            frame_start <= 0;
        end
        line_start <= 1;
        @(posedge clock);
        line_start <= 0;
        active_in <= 1;
        repeat (4) @(posedge clock);
        active_in <= 0;
        repeat (8) @(posedge clock);
    endtask
    // Expected level is the sine code scaled by the amplitude with an arithmetic shift.
    task check_line(input int amp, input logic [2:0] en, input int m);
        int lv;
        chk(32'(mon.q0.size()), 32'd4);
        for (int j = 0; j < 4; j++) begin
            lv = (pat[m][j] * amp) >>> 11;
            chk({16'h0, mon.q0.pop_front()}, en[0] ? {16'h0, lv[15:0]} : 32'h0);
            chk({16'h0, mon.q1.pop_front()}, en[1] ? {16'h0, lv[15:0]} : 32'h0);
            chk({16'h0, mon.q2.pop_front()}, en[2] ? {16'h0, lv[15:0]} : 32'h0);
        end
    endtask
    task coef(input int idx, input logic [23:0] d);
        wr(A_COEF0 + 8'(4 * idx), {8'h0, d});
    endtask
    initial begin
        #500000;
        errors++;
        results();
    end
    initial begin
        repeat (20) @(posedge clock);
        srst <= 0;
        @(posedge clock);
        rd(A_AMP, 32'h578);
        rd(A_CTRL, 32'h1);
        rd(8'h34, 32'h0);
        wr(8'h34, xs());
        rd(8'h34, 32'h0);
        for (int i = 0; i < N_COEF; i++) begin
            v = xs();
            coef(i, v[23:0]);
            rd(A_COEF0 + 8'(4 * i), {{8{v[23]}}, v[23:0]});
        end
        wr(A_AMP, 32'h7ff);
        rd(A_AMP, 32'h63c);
        wr(A_CTRL, 32'h18);
        rd(A_CTRL, 32'hf);
        rd(A_AMP, 32'h578);
        rd(A_COEF0 + 8'h4, 32'h0);
        reg_rd <= 1;
        reg_addr <= A_AMP;
        @(posedge clock);
        reg_rd <= 0;
        clk_en <= 0;
        @(posedge clock);
        chk(reg_rdata, 32'h578);
        repeat (2) @(posedge clock);
        chk(reg_rdata, 32'h578);
        clk_en <= 1;
        repeat (2) @(posedge clock);
        chk(reg_rdata, 32'h0);
        wr(A_CTRL, 32'h10);
        rd(A_CTRL, 32'h1);
        coef(C_PHI, 24'h400000);
        coef(C_X, 24'h400000);
        for (int n = 0; n < 8; n++) begin
            v = xs();
            a = (n == 0) ? 0 : (n == 1) ? 32'(AMP_MAX) : int'(v[10:0] % 11'd1597);
            e = (n < 2) ? 3'h7 : v[14:12];
            wr(A_AMP, 32'(a));
            wr(A_CTRL, {29'h0, e});
            rd(A_AMP, 32'(a));
            run_line(1);
            check_line(a, e, 0);
        end
        coef(C_X, 24'h0);
        run_line(1);
        check_line(a, e, 1);
        coef(C_PHI, 24'h0);
        run_line(0);
        check_line(a, e, 1);
        run_line(1);
        check_line(a, e, 2);
        coef(C_PHI, 24'hc00000);
        run_line(1);
        check_line(a, e, 3);
        wr(A_CTRL, 32'h10);
        coef(C_Y, 24'h400000);
        run_line(1);
        check_line(1400, 3'h1, 2);
        run_line(0);
        check_line(1400, 3'h1, 1);
        wr(A_CTRL, 32'h10);
        coef(C_XY, 24'h400000);
        run_line(1);
        check_line(1400, 3'h1, 2);
        run_line(0);
        check_line(1400, 3'h1, 5);
        wr(A_CTRL, 32'h10);
        coef(C_X2, 24'h800000);
        run_line(1);
        check_line(1400, 3'h1, 4);
        wr(A_CTRL, 32'h10);
        coef(C_Y2, 24'h800000);
        run_line(1);
        check_line(1400, 3'h1, 2);
        run_line(0);
        check_line(1400, 3'h1, 3);
        wr(A_CTRL, 32'h10);
        coef(C_T, 24'h400000);
        run_line(1);
        check_line(1400, 3'h1, 1);
        coef(C_T, 24'hc00000);
        run_line(1);
        check_line(1400, 3'h1, 2);
        wr(A_CTRL, 32'h10);
        coef(C_XT, 24'h400000);
        run_line(1);
        check_line(1400, 3'h1, 5);
        rd(A_STAT, 32'h00120001);
        results();
    end
endmodule
